/* File: src/sps_pkg.sv */
// Constants shared by the serial peripheral port slave.
// Assumes an APB3 master on a 32-bit bus and an 8-bit byte address.
//
// What this block does
// - Shift only on edges the master supplies.
// - One shift register, most significant bit first.
// - Buffer holds transmit byte, then received byte.
// - Eighth bit: load buffer, set full, event.
// - Write while shifting dropped, collision flag sticks.
// - Reading the buffer clears the full flag.
// - Byte into full buffer: overflow, drop, halt.
// - Every transfer sends and receives at once.
// - Enable bit claims pins in slave modes; clear releases them.
// - Enabled slave mode owns data and clock pins.
// - Config bit picks one of two select pins.
// - Idle level bit sets serial clock polarity.
// - Sample phase and output edge are selectable.
// - Mode 0100 uses select, 0101 ignores it.
package sps_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int          SPS_AW       = 8;      // Address bits decoded
    localparam int          SPS_DW       = 32;     // Bus data width

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  SPS_OFS_CTRL = 8'h00;  // serial_port_control
    localparam logic [7:0]  SPS_OFS_CFG  = 8'h04;  // Phase, edge, select pin
    localparam logic [7:0]  SPS_OFS_BUF  = 8'h08;  // port_data_buffer
    localparam logic [7:0]  SPS_OFS_STAT = 8'h0c;  // port_status_register
    localparam logic [7:0]  SPS_OFS_IRQ  = 8'h10;  // Sticky event flags
    localparam logic [7:0]  SPS_OFS_MASK = 8'h14;  // Interrupt mask

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          SPS_CTL_WRITE_COLLISION_FLAG = 7;      // write_collision_flag
    localparam int          SPS_CTL_OVF  = 6;      // receive_overflow_flag
    localparam int          SPS_CTL_EN   = 5;      // port_enable_bit
    localparam int          SPS_CTL_CKP  = 4;      // clock_idle_level
    localparam int          SPS_CFG_SMP  = 0;      // input_sample_phase
    localparam int          SPS_CFG_CKE  = 1;      // Output on trailing edge
    localparam int          SPS_CFG_SEL  = 2;      // select_pin_choice
    localparam int          SPS_ST_BF    = 0;      // buffer_full_flag
    localparam int          SPS_ST_BUSY  = 1;      // Byte in progress
    localparam int          SPS_ST_HALT  = 2;      // Halted by overflow
    localparam int          SPS_IRQ_EVT  = 0;      // port_event_flag
    localparam int          SPS_IRQ_COL  = 1;      // Collision event
    localparam int          SPS_IRQ_OVF  = 2;      // Overflow event

    // ------------------------------------------------------------
    // Mode codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  SPS_MODE_SS_ON  = 4'h4; // Slave, select used
    localparam logic [3:0]  SPS_MODE_SS_OFF = 4'h5; // Slave, select ignored
    localparam logic [7:0]  SPS_RST_CTRL = 8'h00;  // Control reset
    localparam logic [2:0]  SPS_RST_CFG  = 3'h0;   // Config reset
    localparam logic [2:0]  SPS_RST_MASK = 3'h0;   // Mask reset
    localparam logic [7:0]  SPS_RST_BUF  = 8'h00;  // Buffer reset

endpackage

/* File: src/sps_slave.sv */
// Serial peripheral port, slave role, with APB register access.
// Assumes an external master drives the serial clock and select;
// the serial clock is sampled by clk_sys_i and must be much slower.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
module sps_slave (
    // Clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_b_i,
    // APB slave
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [sps_pkg::SPS_AW-1:0] paddr_i,
    input  wire logic [sps_pkg::SPS_DW-1:0] pwdata_i,
    output logic      [sps_pkg::SPS_DW-1:0] prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // Serial link pins
    input  wire logic                       sck_i,
    input  wire logic                       sdi_i,
    input  wire logic                       ss_a_b_i,
    input  wire logic                       ss_b_b_i,
    output logic                            sdo_o,
    output logic                            sdo_oe_o,
    output logic                            port_owns_pins_o,
    // Interrupt
    output logic                            irq_o
);
    import sps_pkg::*;

    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SPS_OFF,                            // Port disabled
        SPS_IDLE,                           // Waiting for first edge
        SPS_SHIFT,                          // Byte in progress
        SPS_HALT                            // Stopped by overflow
    } sps_state_t;

    sps_state_t state;                      // Link state
    logic [3:0] pin_raw;                    // Raw pin levels
    logic [3:0] pin_s;                      // Synchronised pin levels
    logic       sck_s;                      // Serial clock, synced
    logic       sdi_s;                      // Serial data in, synced
    logic       sck_d;                      // Clock one cycle later
    logic       rise;                       // Clock rising edge
    logic       fall;                       // Clock falling edge
    logic       lead;                       // Idle to active edge
    logic       trail;                      // Active to idle edge
    logic       out_edge;                   // Edge that moves output
    logic       samp_edge;                  // Edge that samples input

    // Control registers
    logic       write_collision_flag;                       // write_collision_flag
    logic       ovf;                        // receive_overflow_flag
    logic       en;                         // port_enable_bit
    logic       clock_idle_level;                        // clock_idle_level
    logic [3:0] mode;                       // port_mode_field
    logic       input_sample_phase;                        // input_sample_phase
    logic       cke;                        // Output on trailing edge
    logic       sel;                        // select_pin_choice
    logic [2:0] irq_st;                     // Sticky event flags
    logic [2:0] irq_mask;                   // Interrupt mask

    // Data path
    logic [7:0] port_shift_register;        // Shared shift register
    logic [7:0] port_data_buffer;           // Buffer register
    logic       bf;                         // buffer_full_flag
    logic [2:0] cnt;                        // Bits sampled so far
    logic       out_bit;                    // Bit on the data output

    // Decoded control
    logic       slave_mode;                 // Mode is a slave code
    logic       active;                     // Enabled in slave mode
    logic       ss_use;                     // Select input honoured
    logic       ss_b;                       // Chosen select, low active
    logic       deselected;                 // Select honoured and high
    logic       edge_ok;                    // Edges may act now
    logic       samp_take;                  // Sample this cycle
    logic       out_take;                   // Move output this cycle
    logic       done;                       // Eighth bit sampled
    logic       ovf_set;                    // Byte met a full buffer

    // Bus decode
    logic       acc_start;                  // First access cycle
    logic       acc_done;                   // Completing access cycle
    logic       wr;                         // Write takes effect
    logic       rd;                         // Read completes
    logic       hit_ctrl;                   // Control selected
    logic       hit_cfg;                    // Config selected
    logic       hit_buf;                    // Buffer selected
    logic       hit_stat;                   // Status selected
    logic       hit_irq;                    // Event flags selected
    logic       hit_mask;                   // Mask selected
    logic       mapped;                     // Any register selected
    logic       buf_wr;                     // Buffer write accepted
    logic       collide;                    // Buffer write refused
    logic [7:0] rx_byte;                    // Byte just completed
    logic [SPS_DW-1:0] rdata;               // Read mux output

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pin_raw = {ss_b_b_i, ss_a_b_i, sdi_i, sck_i};

    sps_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .d_i       (pin_raw),
        .q_o       (pin_s)
    );

    assign sck_s = pin_s[0];
    assign sdi_s = pin_s[1];

    // Delayed clock for edge detection
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            sck_d <= 1'b0;
        else
            sck_d <= sck_s;
    end

    // ------------------------------------------------------------
    // Edge and mode decode
    // ------------------------------------------------------------
    assign rise       = sck_s & ~sck_d;
    assign fall       = ~sck_s & sck_d;
    assign lead       = clock_idle_level ? fall : rise;
    assign trail      = clock_idle_level ? rise : fall;
    assign out_edge   = cke ? trail : lead;
    assign samp_edge  = input_sample_phase ? out_edge : (cke ? lead : trail);

    assign slave_mode = (mode == SPS_MODE_SS_ON) || (mode == SPS_MODE_SS_OFF);
    assign active     = en & slave_mode;
    assign ss_use     = (mode == SPS_MODE_SS_ON);
    assign ss_b       = sel ? pin_s[3] : pin_s[2];
    assign deselected = ss_use & ss_b;

    // Edges act only in idle or shift and while selected
    assign edge_ok    = ((state == SPS_IDLE) || (state == SPS_SHIFT)) & ~deselected;
    assign samp_take  = edge_ok & samp_edge;
    assign out_take   = edge_ok & out_edge;
    assign done       = samp_take & (cnt == 3'h7);
    assign ovf_set    = done & bf;
    assign rx_byte    = {port_shift_register[6:0], sdi_s};

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign acc_start = psel_i & penable_i & ~pready_o;
    assign acc_done  = psel_i & penable_i & pready_o;
    assign wr        = acc_done & pwrite_i;
    assign rd        = acc_done & ~pwrite_i;
    assign hit_ctrl  = (paddr_i == SPS_OFS_CTRL);
    assign hit_cfg   = (paddr_i == SPS_OFS_CFG);
    assign hit_buf   = (paddr_i == SPS_OFS_BUF);
    assign hit_stat  = (paddr_i == SPS_OFS_STAT);
    assign hit_irq   = (paddr_i == SPS_OFS_IRQ);
    assign hit_mask  = (paddr_i == SPS_OFS_MASK);
    assign mapped    = hit_ctrl | hit_cfg | hit_buf | hit_stat | hit_irq | hit_mask;

    // Buffer writes refused while a byte is shifting
    assign collide   = wr & hit_buf & (state == SPS_SHIFT);
    assign buf_wr    = wr & hit_buf & (state != SPS_SHIFT);

    // Read data mux
    always_comb
    begin
        rdata = '0;
        case (1'b1)
            hit_ctrl: rdata[7:0] = {write_collision_flag, ovf, en, clock_idle_level, mode};
            hit_cfg:  rdata[2:0] = {sel, cke, input_sample_phase};
            hit_buf:  rdata[7:0] = port_data_buffer;
            hit_stat:
            begin
                rdata[SPS_ST_BF]   = bf;
                rdata[SPS_ST_BUSY] = (state == SPS_SHIFT);
                rdata[SPS_ST_HALT] = (state == SPS_HALT);
            end
            hit_irq:  rdata[2:0] = irq_st;
            hit_mask: rdata[2:0] = irq_mask;
            default:  rdata = '0;
        endcase
    end

    // Bus answer, one wait cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end
        else
        begin
            pready_o  <= acc_start;
            pslverr_o <= acc_start & ~mapped;
            prdata_o  <= (acc_start & ~pwrite_i) ? rdata : '0;
        end
    end

    // ------------------------------------------------------------
    // Control and configuration registers
    // ------------------------------------------------------------
    // Enable, idle level and mode
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            en   <= SPS_RST_CTRL[SPS_CTL_EN];
            clock_idle_level  <= SPS_RST_CTRL[SPS_CTL_CKP];
            mode <= SPS_RST_CTRL[3:0];
        end
        else if (wr & hit_ctrl)
        begin
            en   <= pwdata_i[SPS_CTL_EN];
            clock_idle_level  <= pwdata_i[SPS_CTL_CKP];
            mode <= pwdata_i[3:0];
        end
    end

    // Collision flag: set wins, software writes zero to clear
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            write_collision_flag <= SPS_RST_CTRL[SPS_CTL_WRITE_COLLISION_FLAG];
        else if (collide)
            write_collision_flag <= 1'b1;
        else if (wr & hit_ctrl)
            write_collision_flag <= write_collision_flag & pwdata_i[SPS_CTL_WRITE_COLLISION_FLAG];
    end

    // Overflow flag: set wins, software writes zero to clear
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ovf <= SPS_RST_CTRL[SPS_CTL_OVF];
        else if (ovf_set)
            ovf <= 1'b1;
        else if (wr & hit_ctrl)
            ovf <= ovf & pwdata_i[SPS_CTL_OVF];
    end

    // Phase, output edge and select pin choice
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            {sel, cke, input_sample_phase} <= SPS_RST_CFG;
        else if (wr & hit_cfg)
        begin
            input_sample_phase <= pwdata_i[SPS_CFG_SMP];
            cke <= pwdata_i[SPS_CFG_CKE];
            sel <= pwdata_i[SPS_CFG_SEL];
        end
    end

    // ------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state <= SPS_OFF;
        else if (!active)
            state <= SPS_OFF;
        else
        begin
            case (state)
                SPS_OFF:
                    state <= SPS_IDLE;
                SPS_IDLE:
                    // First master edge opens a byte
                    if (samp_take | out_take)
                        state <= SPS_SHIFT;
                SPS_SHIFT:
                    if (deselected)
                        state <= SPS_IDLE;
                    else if (ovf_set)
                        state <= SPS_HALT;
                    else if (done)
                        state <= SPS_IDLE;
                SPS_HALT:
                    // Resume once overflow is cleared
                    if (!ovf)
                        state <= SPS_IDLE;
                default:
                    state <= SPS_OFF;
            endcase
        end
    end

    // Bit counter, cleared whenever edges may not act
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt <= 3'h0;
        else if (!edge_ok)
            cnt <= 3'h0;
        else if (samp_take)
            cnt <= cnt + 3'h1;
    end

    // ------------------------------------------------------------
    // Shift register and output bit
    // ------------------------------------------------------------
    // Loaded by buffer write, shifts in at sample edges
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            port_shift_register <= SPS_RST_BUF;
        else if (buf_wr)
            port_shift_register <= pwdata_i[7:0];
        else if (samp_take)
            port_shift_register <= rx_byte;
    end

    // Output bit moves at output edges, top bit first
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            out_bit <= 1'b0;
        else if (buf_wr)
            out_bit <= pwdata_i[7];
        else if (out_take)
            out_bit <= samp_take ? port_shift_register[6]
                                 : port_shift_register[7];
    end

    // ------------------------------------------------------------
    // Buffer register and full flag
    // ------------------------------------------------------------
    // Holds transmit byte until a received byte replaces it
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            port_data_buffer <= SPS_RST_BUF;
        else if (done & ~bf)
            port_data_buffer <= rx_byte;
        else if (buf_wr)
            port_data_buffer <= pwdata_i[7:0];
    end

    // Full flag: completion wins over a read in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            bf <= 1'b0;
        else if (done)
            bf <= 1'b1;
        else if (rd & hit_buf)
            bf <= 1'b0;
    end

    // ------------------------------------------------------------
    // Interrupt flags, mask and output
    // ------------------------------------------------------------
    // Sticky events, write one to clear, set wins
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            irq_st <= 3'h0;
        else
            irq_st <= (irq_st & ~((wr & hit_irq) ? pwdata_i[2:0] : 3'h0))
                    | {ovf_set, collide, done};
    end

    // Mask register
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            irq_mask <= SPS_RST_MASK;
        else if (wr & hit_mask)
            irq_mask <= pwdata_i[2:0];
    end

    // Level interrupt while any unmasked flag is set
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_st & irq_mask);
    end

    // ------------------------------------------------------------
    // Pin ownership and data output
    // ------------------------------------------------------------
    // Claim pins while enabled in slave mode; drive output unless select is honoured and high
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            port_owns_pins_o <= 1'b0;
            sdo_oe_o         <= 1'b0;
        end
        else
        begin
            port_owns_pins_o <= active;
            sdo_oe_o         <= active & ~deselected;
        end
    end

    // Data output straight from the output bit flop
    assign sdo_o = out_bit;

endmodule

/* File: src/sps_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous levels; only the second stage is read.
`timescale 1ns/1ps
module sps_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    // Raw and synchronised levels
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    // ------------------------------------------------------------
    // One flop pair per input bit
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic meta;                     // First stage, read by q only

            // Two flops in series
            always_ff @(posedge clk_sys_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    meta   <= 1'b0;
                    q_o[g] <= 1'b0;
                end
                else
                begin
                    meta   <= d_i[g];
                    q_o[g] <= meta;
                end
            end
        end
    endgenerate

endmodule

/* File: testbench/sps_assertions.sv */
// Port-level checks for the serial port slave.
// Assumes binding onto sps_slave; one clock domain.
`timescale 1ns/1ps
module sps_assertions (
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        sdo_oe_o,
    input wire logic        port_owns_pins_o
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic bad_addr; // Outside the register map
    assign bad_addr = (paddr_i > 8'h14) || (paddr_i[1:0] != 2'h0);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    sequence wait_s; psel_i && penable_i && !pready_o; endsequence
    sequence done_s; pready_o && psel_i && penable_i; endsequence
    sequence ctl_s; done_s ##0 pwrite_i && paddr_i == 8'h00; endsequence
    // Bus answer timing
    apb_wait_a: assert property (wait_s |=> pready_o) else $error("no answer after one wait");
    apb_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
    apb_cause_a: assert property (pready_o |-> $past(psel_i && penable_i)) else $error("ready without access");
    err_map_a: assert property ((done_s ##0 bad_addr) |-> pslverr_o) else $error("unmapped not flagged");
    err_only_a: assert property (pslverr_o |-> pready_o && bad_addr) else $error("spurious error");
    rdata_idle_a: assert property (!pready_o || pwrite_i |-> prdata_o == 32'h0) else $error("read data leaks");
    // Pin ownership
    own_on_a:
        assert property ((ctl_s ##0 pwdata_i[5] && pwdata_i[3:0] inside {4'h4, 4'h5}) |=> ##[0:2] port_owns_pins_o)
        else $error("pins not claimed");
    own_off_a:
        assert property ((ctl_s ##0 !pwdata_i[5]) |=> ##[0:2] !port_owns_pins_o) else $error("pins not released");
    oe_owns_a: assert property (sdo_oe_o |-> port_owns_pins_o) else $error("drives pin not owned");
endmodule

/* File: testbench/sps_master_model.sv */
// Behavioural serial master: idle-low clock, samples on leading edge.
// Assumes the slave is set for output on trailing edge.
`timescale 1ns/1ps
module sps_master_model (
    output logic      sck_o,
    output logic      sdi_o,
    output logic      ss_b_o,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i
);
    initial
    begin
        sck_o = 1'b0;
        sdi_o = 1'b0;
        ss_b_o = 1'b1;
    end
    // One byte each way, 320 ns clock period, stands still outside
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        ss_b_o = 1'b0;
        #400;
        for (int i = 7; i >= 0; i--)
        begin
            sdi_o = tx[i];
            #160;
            rx[i] = sdo_oe_i ? sdo_i : 1'bx;
            sck_o = 1'b1;
            #160;
            sck_o = 1'b0;
        end
        #400;
        ss_b_o = 1'b1;
        sdi_o = ~sdi_o; // Inverted: no stale bit
    endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for sps_slave: APB driver, queue monitor.
// Assumes sps_pkg and the master model are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench;
    import sps_pkg::*;
    logic        clk_sys_i, rst_b_i, psel, penable, pwrite, sck, sdi, ss_a;
    logic        pready, pslverr, sdo, sdo_oe, owns, irq, ss_b;
    logic [7:0]  paddr, tx, b1, b2, m;
    logic [31:0] pwdata, prdata;
    logic [32:0] exp_q[$], e_cur;
    int          n_checks = 0, n_mismatch = 0;
    sps_slave i_sps_slave (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sck_i(sck), .sdi_i(sdi), .ss_a_b_i(ss_a), .ss_b_b_i(ss_b), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .port_owns_pins_o(owns), .irq_o(irq));
    sps_master_model i_mst (.sck_o(sck), .sdi_o(sdi), .ss_b_o(ss_a), .sdo_i(sdo), .sdo_oe_i(sdo_oe));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // APB transfer; expected {pslverr, prdata} noted in queue
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys_i);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(negedge clk_sys_i); while (pready !== 1'b1);
        @(posedge clk_sys_i);
        {psel, penable} <= 2'b00;
    endtask
    // Settled pin levels {sdo_oe, owns, irq}
    task automatic pins(input logic [2:0] e);
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        `CHK("pins", e, {sdo_oe, owns, irq})
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Monitor: oldest note against each answer
    always @(negedge clk_sys_i)
        if (pready === 1'b1)
        begin
            e_cur = exp_q.pop_front();
            `CHK("apb", e_cur, {pslverr, prdata})
        end
    initial
    begin
        #200000;
        n_mismatch++;
        stop_test;
    end
    initial
    begin
        {rst_b_i, psel, penable, pwrite, paddr, pwdata} = '0;
        ss_b = 1'b1;
        void'($urandom(52));
        repeat (20) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        apb(0, SPS_OFS_CTRL, 0, {25'h0, SPS_RST_CTRL});
        apb(1, SPS_OFS_CTRL, 32'h25, 0);
        pins(3'b110);
        apb(1, SPS_OFS_CTRL, 32'h24, 0);
        pins(3'b010);
        ss_b <= 1'b0;
        apb(1, SPS_OFS_CFG, 32'h4, 0);
        pins(3'b110);
        ss_b <= 1'b1;
        apb(1, SPS_OFS_CFG, 32'h2, 0);
        apb(1, SPS_OFS_MASK, 32'h7, 0);
        tx = $urandom;
        b1 = $urandom;
        b2 = $urandom;
        apb(1, SPS_OFS_BUF, {24'h0, tx}, 0);
        i_mst.xfer(b1, m);
        `CHK("sdo", tx, m)
        pins(3'b011);
        apb(0, SPS_OFS_STAT, 0, 33'h1);
        apb(0, SPS_OFS_BUF, 0, {25'h0, b1});
        apb(0, SPS_OFS_STAT, 0, 33'h0);
        apb(1, SPS_OFS_IRQ, 32'h1, 0);
        pins(3'b010);
        i_mst.xfer(b2, m);
        fork
            i_mst.xfer(~b2, m);
            #1500 apb(1, SPS_OFS_BUF, 32'h55, 0);
        join
        apb(0, SPS_OFS_CTRL, 0, 33'he4);
        apb(0, SPS_OFS_BUF, 0, {25'h0, b2});
        apb(0, SPS_OFS_IRQ, 0, 33'h7);
        apb(1, SPS_OFS_MASK, 0, 0);
        pins(3'b010);
        apb(1, 8'h18, 32'hff, 33'h100000000);
        apb(0, 8'h18, 0, 33'h100000000);
        apb(1, SPS_OFS_CTRL, 0, 0);
        pins(3'b000);
        stop_test;
    end
endmodule
bind sps_slave sps_assertions i_chk (.*);
